// file: tmr_regs.svh
// register indices, reset values and rate counts of the up/down timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TMR_IDX_CTRL 10'h0C8
`define TMR_IDX_MODE 10'h0C9
`define TMR_IDX_RLD_LO 10'h0CA
`define TMR_IDX_RLD_HI 10'h0CB
`define TMR_IDX_CNT_LO 10'h0CC
`define TMR_IDX_CNT_HI 10'h0CD
`define TMR_ADR_IDX_MSB 11
`define TMR_ADR_IDX_LSB 2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TMR_CTRL_MSB 7
`define TMR_MODE_MSB 1
`define TMR_RUN_BIT 2

// ----------------------------------------------------------------------
// reset values and counter maximum
// ----------------------------------------------------------------------
`define TMR_CTRL_RST 8'h00
`define TMR_MODE_RST 2'h0
`define TMR_CNT_RST 16'h0000
`define TMR_RLD_RST 16'h0000
`define TMR_CNT_MAX 16'hFFFF

// ----------------------------------------------------------------------
// core clock cycles per count (core clock is the oscillator)
// ----------------------------------------------------------------------
`define TMR_DIV_6CLK 4'h6
`define TMR_DIV_12CLK 4'hC
`define TMR_DIV_FAST_6CLK 4'h1
`define TMR_DIV_FAST_12CLK 4'h2

`endif

// file: tmr_pkg.sv
// types shared by the up/down timer and its bus
`default_nettype none

package tmr_pkg;

   // ----------------------------------------------------------------------
   // classic wishbone carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tmr_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } tmr_wb_rsp_s;

   // ----------------------------------------------------------------------
   // control register, bit 7 down to bit 0
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic ovfFlag;
      logic extFlag;
      logic rxBaudSel;
      logic txBaudSel;
      logic extEventEn;
      logic runCtrl;
      logic countSrcSel;
      logic captureSel;
   } tmr_ctrl_s;

   typedef struct packed {
      logic clkoutEn;
      logic downCountEn;
   } tmr_mode_s;

   // ----------------------------------------------------------------------
   // whole state of the timer
   // ----------------------------------------------------------------------
   typedef struct packed {
      tmr_ctrl_s ctrl;
      tmr_mode_s mode;
      logic [15:0] reload;
      logic [15:0] cnt;
      logic [3:0] presc;
      logic trigPrev;
      logic evPrev;
      logic clkoutLevel;
      logic baudPulse;
      logic ack;
      logic [31:0] rdData;
   } tmr_state_s;

endpackage : tmr_pkg

`default_nettype wire

// file: tmr_updown_timer.sv
// 16-bit up/down timer with capture, auto-reload, baud pulse and clock out
//
// Notes on behaviour
// - 16-bit counter, timer or event counter; capture, reload and baud modes.
// - capture mode keeps counting after capture; timer rate osc/6 or osc/12.
// - capture mode without trigger enable sets ovf_flag on rollover.
// - trigger falling edge copies counter into reload and sets ext_flag.
// - both flags share one interrupt request; software reads both.
// - reset clears down_count_en; when set, trigger pin level picks direction.
// - up-only reload: overflow past 0FFFFH sets ovf_flag and loads reload.
// - up-only reload with trigger: edge also reloads and sets ext_flag.
// - up/down mode, pin high: count up, overflow sets flag, loads reload.
// - up/down mode, pin low: count down, match reload sets flag, loads 0FFFFH.
// - up/down mode: ext_flag toggles on each roll, raises no interrupt.
// - clock out driven when source is internal, clkout_en and run set.
// - clock out frequency is osc over n times (65536 minus reload).
// - clock-out rollovers raise no interrupt.
// - baud and clock out may run together at the same rollover rate.
// - clock-out pin can instead be the external count input.
// - ovf_flag sticky until cleared; never set while timer clocks serial port.
// - source select 0 counts divided oscillator, 1 counts falling edges.
// - trigger edges act only with enable set, serial port not clocked and up/down mode off.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "tmr_regs.svh"
`default_nettype none

module tmr_updown_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register bus
   input wire tmr_pkg::tmr_wb_req_s wbReq,
   output var tmr_pkg::tmr_wb_rsp_s wbRsp,
   // configuration strap, high selects twelve-clock mode
   input wire logic twelveClkMode,
   // pins
   input wire logic extTrigPin,
   input wire logic clkoutPinIn,
   output logic clkoutPinOut,
   output logic clkoutPinOe,
   // serial port and interrupt controller
   output logic baudPulse,
   output logic timerIrq
);
   import tmr_pkg::*;

   // ----------------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------------
   function automatic logic [31:0] regRead(input tmr_state_s s, input logic [9:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         `TMR_IDX_CTRL: b = s.ctrl;
         `TMR_IDX_MODE: b = {6'h00, s.mode};
         `TMR_IDX_RLD_LO: b = s.reload[7:0];
         `TMR_IDX_RLD_HI: b = s.reload[15:8];
         `TMR_IDX_CNT_LO: b = s.cnt[7:0];
         `TMR_IDX_CNT_HI: b = s.cnt[15:8];
         default: b = 8'h00;
      endcase
      return {24'h000000, b};
   endfunction : regRead

   tmr_state_s st_ff;
   tmr_state_s nxt_st;

   logic busHit;
   logic regWr;
   logic [9:0] wrIdx;
   logic baudMode;
   logic clkoutMode;
   logic captMode;
   logic udMode;
   logic dirDown;
   logic fastRate;
   logic [3:0] divCnt;
   logic intTick;
   logic extFall;
   logic tick;
   logic trigFall;
   logic trigEv;
   logic rollUp;
   logic rollDown;
   logic rollEv;
   logic ovfSet;

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   assign busHit = wbReq.cyc & wbReq.stb;
   // writes land on the edge where the master sees ack
   assign regWr = busHit & wbReq.we & st_ff.ack & wbReq.sel[0];
   assign wrIdx = wbReq.adr[`TMR_ADR_IDX_MSB:`TMR_ADR_IDX_LSB];
   assign baudMode = st_ff.ctrl.rxBaudSel | st_ff.ctrl.txBaudSel;
   assign clkoutMode = st_ff.mode.clkoutEn & ~st_ff.ctrl.countSrcSel;
   // baud use forces auto-reload, so capture yields to it
   assign captMode = st_ff.ctrl.captureSel & ~baudMode;
   assign udMode = st_ff.mode.downCountEn & ~captMode & ~baudMode;
   assign dirDown = udMode & ~extTrigPin;

   // ----------------------------------------------------------------------
   // count rate
   // ----------------------------------------------------------------------
   // fast rate gives osc over 2 or 4 per output period count
   assign fastRate = baudMode | clkoutMode;
   assign divCnt = fastRate ? (twelveClkMode ? `TMR_DIV_FAST_12CLK : `TMR_DIV_FAST_6CLK)
                            : (twelveClkMode ? `TMR_DIV_12CLK : `TMR_DIV_6CLK);
   assign intTick = (st_ff.presc == divCnt - 4'h1);
   assign extFall = st_ff.evPrev & ~clkoutPinIn;
   assign tick = st_ff.ctrl.runCtrl & (st_ff.ctrl.countSrcSel ? extFall : intTick);

   // ----------------------------------------------------------------------
   // events
   // ----------------------------------------------------------------------
   assign trigFall = st_ff.trigPrev & ~extTrigPin;
   // edges gated by enable, serial use and up/down mode
   assign trigEv = trigFall & st_ff.ctrl.extEventEn & ~baudMode & ~udMode;
   assign rollUp = tick & ~dirDown & (st_ff.cnt == `TMR_CNT_MAX);
   assign rollDown = tick & dirDown & (st_ff.cnt == st_ff.reload);
   assign rollEv = rollUp | rollDown;
   // no flag in clock out; none in baud use
   assign ovfSet = rollEv & ~baudMode & ~clkoutMode;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.trigPrev = extTrigPin;
      nxt_st.evPrev = clkoutPinIn;
      nxt_st.ack = busHit & ~st_ff.ack;
      if (busHit && !st_ff.ack) begin
         nxt_st.rdData = regRead(st_ff, wrIdx);
      end
      if (!st_ff.ctrl.runCtrl || intTick) begin
         nxt_st.presc = 4'h0;
      end else begin
         nxt_st.presc = st_ff.presc + 4'h1;
      end
      if (tick) begin
         if (rollDown) begin
            nxt_st.cnt = `TMR_CNT_MAX;
         end else if (rollUp) begin
            // capture mode wraps with no reload; reload
            nxt_st.cnt = captMode ? `TMR_CNT_RST : st_ff.reload;
         end else if (dirDown) begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
         end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
      end
      if (trigEv) begin
         if (captMode) begin
            nxt_st.reload = st_ff.cnt;
         end else begin
            nxt_st.cnt = st_ff.reload;
         end
      end
      // one-cycle pulse; shares the rollover with clock out
      nxt_st.baudPulse = rollEv & baudMode;
      if (!clkoutMode || !st_ff.ctrl.runCtrl) begin
         nxt_st.clkoutLevel = 1'b0;
      end else if (rollEv) begin
         nxt_st.clkoutLevel = ~st_ff.clkoutLevel;
      end
      // software writes; data registers take the written byte over counting
      if (regWr) begin
         case (wrIdx)
            `TMR_IDX_CTRL: nxt_st.ctrl = tmr_ctrl_s'(wbReq.dat[`TMR_CTRL_MSB:0]);
            `TMR_IDX_MODE: nxt_st.mode = tmr_mode_s'(wbReq.dat[`TMR_MODE_MSB:0]);
            `TMR_IDX_RLD_LO: nxt_st.reload[7:0] = wbReq.dat[7:0];
            `TMR_IDX_RLD_HI: nxt_st.reload[15:8] = wbReq.dat[7:0];
            `TMR_IDX_CNT_LO: nxt_st.cnt[7:0] = wbReq.dat[7:0];
            `TMR_IDX_CNT_HI: nxt_st.cnt[15:8] = wbReq.dat[7:0];
            default: nxt_st.ctrl = st_ff.ctrl;
         endcase
      end
      // hardware set wins over a software clear
      if (ovfSet) begin
         nxt_st.ctrl.ovfFlag = 1'b1;
      end
      if (trigEv) begin
         nxt_st.ctrl.extFlag = 1'b1;
      end
      if (rollEv && udMode) begin
         nxt_st.ctrl.extFlag = ~st_ff.ctrl.extFlag;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.ctrl <= tmr_ctrl_s'(`TMR_CTRL_RST);
         st_ff.mode <= tmr_mode_s'(`TMR_MODE_RST);
         st_ff.reload <= `TMR_RLD_RST;
         st_ff.cnt <= `TMR_CNT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign wbRsp = '{ack: st_ff.ack, dat: st_ff.rdData};
   assign clkoutPinOut = st_ff.clkoutLevel;
   // drive pin only in clock out mode while running
   assign clkoutPinOe = clkoutMode & st_ff.ctrl.runCtrl;
   assign baudPulse = st_ff.baudPulse;
   // one request; ext flag silent in up/down mode
   assign timerIrq = st_ff.ctrl.ovfFlag | (st_ff.ctrl.extFlag & ~udMode);

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cbAst @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence sCapture;
      trigEv && captMode && !regWr;
   endsequence

   sequence sCaptured;
      st_ff.ctrl.extFlag && (st_ff.reload == $past(st_ff.cnt));
   endsequence

   sequence sUpRollReload;
      rollUp && !captMode && !udMode && !regWr && !trigEv;
   endsequence

   AST_CAPTURE: assert property (sCapture |=> sCaptured)
      else $error("capture did not copy counter or set ext flag");

   AST_UP_RELOAD: assert property (sUpRollReload |=>
         st_ff.cnt == $past(st_ff.reload))
      else $error("overflow did not load reload value");

   AST_OVF_SET: assert property ((rollUp && !baudMode && !clkoutMode)
         |=> st_ff.ctrl.ovfFlag && timerIrq)
      else $error("overflow flag or request missing after rollover");

   // clock-out use keeps the flag quiet, so only plain up/down use is held to it
   AST_DOWN_UNDER: assert property ((rollDown && !regWr && !clkoutMode) |=>
         st_ff.cnt == 16'hFFFF && st_ff.ctrl.ovfFlag)
      else $error("underflow did not load all ones");

   AST_UD_TOGGLE: assert property ((rollEv && udMode) |=>
         st_ff.ctrl.extFlag != $past(st_ff.ctrl.extFlag))
      else $error("ext flag did not toggle in up/down mode");

   AST_BAUD_NO_FLAG: assert property ((rollEv && baudMode && !st_ff.ctrl.ovfFlag && !regWr)
         |=> baudPulse && !st_ff.ctrl.ovfFlag)
      else $error("baud rollover set flag or gave no pulse");

   // a reload of all ones rolls every tick, so width is judged per rollover
   AST_BAUD_PULSE_WIDTH: assert property (!rollEv |=> !baudPulse)
      else $error("baud pulse without a rollover");

   AST_TRIG_IGNORED: assert property ((trigFall && baudMode && !regWr && !tick)
         |=> $stable(st_ff.cnt) && $stable(st_ff.reload))
      else $error("trigger edge acted while serial port clocked");

   AST_CLKOUT_TOGGLE: assert property ((rollEv && clkoutMode && st_ff.ctrl.runCtrl && !regWr)
         |=> clkoutPinOut != $past(clkoutPinOut) && clkoutPinOe)
      else $error("clock out did not toggle at rollover");

   AST_SIX_CLK_RATE: assert property ((intTick && !fastRate && !twelveClkMode
         && st_ff.ctrl.runCtrl && !regWr) |=> (!intTick || fastRate) [*5])
      else $error("timer ticked faster than osc/6");

   AST_CAPT_WRAP: assert property ((rollUp && captMode && !regWr)
         |=> st_ff.cnt == `TMR_CNT_RST)
      else $error("capture mode reloaded instead of wrapping");

   AST_UP_STEP: assert property ((tick && !rollEv && !dirDown && !trigEv && !regWr)
         |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
      else $error("counter did not step up by one");

   AST_DOWN_STEP: assert property ((tick && dirDown && !rollDown && !regWr)
         |=> st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
      else $error("counter did not step down by one");

   AST_UD_NO_EXT_IRQ: assert property (udMode |-> timerIrq == st_ff.ctrl.ovfFlag)
      else $error("ext flag raised a request in up/down mode");

   AST_DIR_UP: assert property (!st_ff.mode.downCountEn |-> !dirDown)
      else $error("counted down with down count disabled");

endmodule : tmr_updown_timer

`default_nettype wire

// file: tmr_far_side.sv
// far-side model: trigger pin, shared clock-out pin wire and serial port
`default_nettype none

module tmr_far_side (
   // clock
   input wire logic core_clk,
   // clock-out pin as driven by the timer, and the serial bit clock
   input wire logic clkoutPinOut,
   input wire logic clkoutPinOe,
   input wire logic baudPulse,
   // pins seen by the timer
   output var logic extTrigPin,
   output wire logic clkoutPinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   import tmr_pkg::*;

   // ----
   // pin wire and event timing
   // ----
   // pulled up while the timer releases the pin
   logic extLvl = 1'b1;
   logic pinPrev = 1'b0;
   initial extTrigPin = 1'b1;
   assign clkoutPinIn = clkoutPinOe ? clkoutPinOut : extLvl;
   always @(posedge core_clk) pinPrev <= clkoutPinOut;

   task automatic setTrig(input logic v);
      extTrigPin <= v;
      @(posedge core_clk);
   endtask : setTrig

   task automatic trigFall;
      setTrig(1'b1);
      setTrig(1'b0);
      @(posedge core_clk);
   endtask : trigFall

   task automatic extEdges(input int n);
      for (int k = 0; k < n; k++) begin
         extLvl <= 1'b0;
         repeat (2) @(posedge core_clk);
         extLvl <= 1'b1;
         repeat (2) @(posedge core_clk);
      end
   endtask : extEdges

   // serial port takes one pulse per rollover
   task automatic gapOf(input logic useBaud, output int g);
      int n;
      g = 0;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge core_clk);
            n++;
         end while (!(useBaud ? baudPulse === 1'b1 : clkoutPinOut !== pinPrev) && n < 100);
         g = n;
      end
   endtask : gapOf
endmodule : tmr_far_side

`default_nettype wire

// file: tmr_updown_timer_test.sv
// self-checking bench for the up/down timer
`include "tmr_regs.svh"
`default_nettype none

module tmr_updown_timer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import tmr_pkg::*;

   // ----
   // signals and instances
   // ----
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic twelveClkMode = 1'b0;
   tmr_wb_req_s wbReq = '0;
   tmr_wb_rsp_s wbRsp;
   logic extTrigPin;
   wire logic clkoutPinIn;
   logic clkoutPinOut, clkoutPinOe, baudPulse, timerIrq;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   tmr_updown_timer uut (.core_clk(core_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
      .twelveClkMode(twelveClkMode), .extTrigPin(extTrigPin), .clkoutPinIn(clkoutPinIn),
      .clkoutPinOut(clkoutPinOut), .clkoutPinOe(clkoutPinOe), .baudPulse(baudPulse),
      .timerIrq(timerIrq));
   tmr_far_side peer (.core_clk(core_clk), .clkoutPinOut(clkoutPinOut),
      .clkoutPinOe(clkoutPinOe), .baudPulse(baudPulse), .extTrigPin(extTrigPin),
      .clkoutPinIn(clkoutPinIn));

   initial begin
      forever #50 core_clk = ~core_clk;
   end

   // a hang costs one mismatch and ends the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end

   // ----
   // bus, compare and report
   // ----
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // entered just after a rising edge; holds the request until ack is sampled
   task automatic wbCycle(input logic w, input logic [9:0] idx, input logic [7:0] wd,
         output logic [7:0] rdv);
      wbReq <= '{1'b1, 1'b1, w, {idx, 2'b00}, 4'hF, {24'h000000, wd}};
      // ends when ack is sampled; with no ack only the bench timeout ends this wait
      do begin
         @(posedge core_clk);
      end while (wbRsp.ack !== 1'b1);
      rdv = wbRsp.dat[7:0];
      wbReq <= '0;
      @(posedge core_clk);
   endtask : wbCycle

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] x;
      wbCycle(1'b1, idx, d, x);
   endtask : wr

   task automatic rdChk(input logic [9:0] idx, input logic [7:0] e);
      logic [7:0] x;
      wbCycle(1'b0, idx, 8'h00, x);
      chk8(x, e);
   endtask : rdChk

   task automatic doReset(input logic m);
      srst <= 1'b1;
      twelveClkMode <= m;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
   endtask : doReset

   // ----
   // scenarios
   // ----
   task automatic testReset;
      rdChk(`TMR_IDX_CTRL, 8'h00);
      rdChk(`TMR_IDX_MODE, 8'h00);
      rdChk(`TMR_IDX_CNT_HI, 8'h00);
      wr(10'h001, 8'h5A);
      rdChk(10'h001, 8'h00);
      chk8({7'h00, timerIrq}, 8'h00);
      $display("test reset done");
   endtask : testReset

   task automatic testClkOut(input logic m);
      int g;
      doReset(m);
      wr(`TMR_IDX_RLD_LO, 8'hFE);
      wr(`TMR_IDX_RLD_HI, 8'hFF);
      // start near the top so the first rollover is not 65536 counts away
      wr(`TMR_IDX_CNT_LO, 8'hFE);
      wr(`TMR_IDX_CNT_HI, 8'hFF);
      wr(`TMR_IDX_MODE, 8'h02);
      wr(`TMR_IDX_CTRL, 8'h04);
      peer.gapOf(1'b0, g);
      // half period is n*(65536-FFFE)/2 core cycles
      chk8(8'(g), m ? 8'h04 : 8'h02);
      chk8({7'h00, clkoutPinOe}, 8'h01);
      rdChk(`TMR_IDX_CTRL, 8'h04);
      chk8({7'h00, timerIrq}, 8'h00);
      wr(`TMR_IDX_CTRL, 8'h14);
      peer.gapOf(1'b1, g);
      chk8(8'(g), m ? 8'h04 : 8'h02);
      rdChk(`TMR_IDX_CTRL, 8'h14);
      wr(`TMR_IDX_CTRL, 8'h00);
      chk8({7'h00, clkoutPinOe}, 8'h00);
      $display("test clock out done");
   endtask : testClkOut

   task automatic testCapture;
      doReset(1'b0);
      wr(`TMR_IDX_CNT_LO, 8'hFE);
      wr(`TMR_IDX_CNT_HI, 8'hFF);
      wr(`TMR_IDX_CTRL, 8'h0D);
      repeat (20) @(posedge core_clk);
      rdChk(`TMR_IDX_CTRL, 8'h8D);
      chk8({7'h00, timerIrq}, 8'h01);
      wr(`TMR_IDX_CTRL, 8'h09);
      wr(`TMR_IDX_CNT_LO, 8'h3C);
      wr(`TMR_IDX_CNT_HI, 8'hA5);
      peer.trigFall();
      rdChk(`TMR_IDX_RLD_LO, 8'h3C);
      rdChk(`TMR_IDX_RLD_HI, 8'hA5);
      rdChk(`TMR_IDX_CTRL, 8'h49);
      chk8({7'h00, timerIrq}, 8'h01);
      $display("test capture done");
   endtask : testCapture

   task automatic testReload;
      doReset(1'b0);
      wr(`TMR_IDX_RLD_LO, 8'h34);
      wr(`TMR_IDX_RLD_HI, 8'h12);
      wr(`TMR_IDX_CNT_LO, 8'hFF);
      wr(`TMR_IDX_CNT_HI, 8'hFF);
      wr(`TMR_IDX_CTRL, 8'h0C);
      repeat (8) @(posedge core_clk);
      rdChk(`TMR_IDX_CNT_HI, 8'h12);
      rdChk(`TMR_IDX_CTRL, 8'h8C);
      wr(`TMR_IDX_CTRL, 8'h28);
      wr(`TMR_IDX_CNT_HI, 8'h00);
      peer.trigFall();
      rdChk(`TMR_IDX_CNT_HI, 8'h00);
      rdChk(`TMR_IDX_CTRL, 8'h28);
      wr(`TMR_IDX_CTRL, 8'h08);
      peer.trigFall();
      rdChk(`TMR_IDX_CNT_HI, 8'h12);
      rdChk(`TMR_IDX_CNT_LO, 8'h34);
      rdChk(`TMR_IDX_CTRL, 8'h48);
      $display("test reload done");
   endtask : testReload

   task automatic testUpDown;
      doReset(1'b0);
      peer.setTrig(1'b0);
      wr(`TMR_IDX_MODE, 8'h01);
      wr(`TMR_IDX_RLD_LO, 8'h05);
      wr(`TMR_IDX_CNT_LO, 8'h06);
      wr(`TMR_IDX_CTRL, 8'h04);
      repeat (16) @(posedge core_clk);
      rdChk(`TMR_IDX_CTRL, 8'hC4);
      rdChk(`TMR_IDX_CNT_HI, 8'hFF);
      wr(`TMR_IDX_CTRL, 8'h44);
      chk8({7'h00, timerIrq}, 8'h00);
      peer.setTrig(1'b1);
      wr(`TMR_IDX_CNT_LO, 8'hFF);
      repeat (8) @(posedge core_clk);
      rdChk(`TMR_IDX_CTRL, 8'h84);
      rdChk(`TMR_IDX_CNT_HI, 8'h00);
      $display("test up down done");
   endtask : testUpDown

   task automatic testExtCount;
      doReset(1'b0);
      wr(`TMR_IDX_MODE, 8'h02);
      wr(`TMR_IDX_CTRL, 8'h06);
      peer.extEdges(3);
      rdChk(`TMR_IDX_CNT_LO, 8'h03);
      chk8({7'h00, clkoutPinOe}, 8'h00);
      $display("test event count done");
   endtask : testExtCount

   initial begin
      doReset(1'b0);
      testReset();
      testClkOut(1'b0);
      testClkOut(1'b1);
      testCapture();
      testReload();
      testUpDown();
      testExtCount();
      conclude();
   end
endmodule : tmr_updown_timer_test

`default_nettype wire
